/* logic/abd_datapath.sv */
// Summary of operation
// - Add immediate: accumulator plus 8-bit literal into accumulator, update C, half carry, Z.
// - Add register: accumulator plus addressed file register, update C, half carry, Z.
// - Register arithmetic and AND: dest 0 writes accumulator, dest 1 writes register.
// - AND immediate: accumulator AND literal into accumulator, only Z changes.
// - AND register: accumulator AND register to chosen destination, only Z changes.
// - Bit clear: addressed register bit forced to zero, nothing else changes.
// - Bit set: addressed register bit forced to one, nothing else changes.
// - Skip when zero: tested bit zero discards next instruction, idle cycle instead.
// - Skip when one: tested bit one discards next instruction, idle cycle, no flags.
// - Read-modify-write on the port register reads the pin levels, not latch.
// - Writing the timer-zero counter clears its prescaler when assigned to it.
`timescale 1ns/100ps
`default_nettype none
`include "abd_defines.svh"

module abd_datapath #(
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Instruction issue
  input  wire logic                  instValid,
  input  wire abd_pkg::abd_instr_t   instr,
  // Port pins
  input  wire logic [7:0]            portPins,
  output var  logic [7:0]            portLatch,
  // Timer prescaler
  output var  logic                  prescalerClear,
  // Execute status
  output var  logic [7:0]            accumulator,
  output var  abd_pkg::abd_flags_t   flags,
  output var  logic                  retired,
  output var  logic                  idleCycle,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]          fileMem [FILE_DEPTH];
  logic [7:0]          pinSync1;
  logic [7:0]          pinSync2;
  logic [7:0]          pinSync3;
  logic [7:0]          pinLevel;
  logic                skipPending;
  logic                prescalerAssigned;

  logic [7:0]          operand;
  logic [7:0]          next_result;
  logic                next_carry;
  logic                next_halfCarry;
  logic                writeAcc;
  logic                writeFile;
  logic                updateArith;
  logic                updateZero;
  logic                next_skip;
  logic                execute;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bitMask(input logic [2:0] pos);
    bitMask = 8'h01 << pos;
  endfunction

  function automatic logic apbHit(input logic [7:0] addr);
    apbHit = (addr == `ABD_REG_CTRL) || (addr == `ABD_REG_ACC)
          || (addr == `ABD_REG_STATUS);
  endfunction

  assign execute   = instValid && !skipPending;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    pinSync1 <= portPins;
    pinSync2 <= pinSync1;
    pinSync3 <= pinSync2;
    if (srst)
      pinLevel <= `ABD_PORT_RESET;
    else if (pinSync2 == pinSync3)
      pinLevel <= pinSync3;
  end

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  // pins as source
  assign operand = (instr.fileAddr == `ABD_ADDR_PORT) ? pinLevel
                                                      : fileMem[instr.fileAddr];

  // ----------------------------------------------------------------
  // Execute decode
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [4:0] lowSum;
    logic [8:0] fullSum;
    logic [7:0] addend;
    lowSum         = '0;
    fullSum        = '0;
    addend         = instr.literal;
    next_result    = accumulator;
    next_carry     = flags.carry;
    next_halfCarry = flags.half_carry_flag;
    writeAcc       = 1'b0;
    writeFile      = 1'b0;
    updateArith    = 1'b0;
    updateZero     = 1'b0;
    next_skip      = 1'b0;
    unique case (instr.op)
      abd_pkg::add_immediate_to_accumulator,
      abd_pkg::add_accumulator_and_register:
      begin
        if (instr.op == abd_pkg::add_accumulator_and_register)
          addend = operand;
        // carry from bit 7 and 3
        lowSum         = {1'b0, accumulator[`ABD_NIBBLE_W-1:0]}
                       + {1'b0, addend[`ABD_NIBBLE_W-1:0]};
        fullSum        = {1'b0, accumulator} + {1'b0, addend};
        next_result    = fullSum[`ABD_DATA_W-1:0];
        next_carry     = fullSum[`ABD_DATA_W];
        next_halfCarry = lowSum[`ABD_NIBBLE_W];
        updateArith    = 1'b1;
        updateZero     = 1'b1;
        writeAcc  = (instr.op == abd_pkg::add_immediate_to_accumulator)
                 || (instr.dest == `ABD_DEST_ACC);
        writeFile = !writeAcc;
      end
      abd_pkg::and_immediate_with_accumulator:
      begin
        next_result = accumulator & instr.literal;
        updateZero  = 1'b1;
        writeAcc    = 1'b1;
      end
      abd_pkg::and_accumulator_with_register:
      begin
        next_result = accumulator & operand;
        updateZero  = 1'b1;
        writeAcc    = (instr.dest == `ABD_DEST_ACC);
        writeFile   = !writeAcc;
      end
      abd_pkg::register_bit_clear,
      abd_pkg::register_bit_set:
      begin
        if (instr.op == abd_pkg::register_bit_set)
          next_result = operand | bitMask(instr.bitPos);
        else
          next_result = operand & ~bitMask(instr.bitPos);
        writeFile = 1'b1;
      end
      abd_pkg::test_bit_skip_when_zero,
      abd_pkg::test_bit_skip_when_one:
      begin
        next_skip = operand[instr.bitPos]
                 == (instr.op == abd_pkg::test_bit_skip_when_one);
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Accumulator and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      accumulator <= `ABD_ACC_RESET;
      flags       <= '0;
    end
    else if (execute)
    begin
      if (writeAcc)
        accumulator <= next_result;
      if (updateArith)
      begin
        flags.carry           <= next_carry;
        flags.half_carry_flag <= next_halfCarry;
      end
      if (updateZero)
        flags.zero <= (next_result == `ABD_ZERO_BYTE);
    end
  end

  // ----------------------------------------------------------------
  // File register write-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (execute && writeFile)
      fileMem[instr.fileAddr] <= next_result;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      portLatch <= `ABD_PORT_RESET;
    else if (execute && writeFile && instr.fileAddr == `ABD_ADDR_PORT)
      portLatch <= next_result;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      prescalerClear <= 1'b0;
    else
      prescalerClear <= execute && writeFile && prescalerAssigned
                     && (instr.fileAddr == `ABD_ADDR_TIMER_ZERO);
  end

  // ----------------------------------------------------------------
  // Skip sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      skipPending <= 1'b0;
      retired     <= 1'b0;
      idleCycle   <= 1'b0;
    end
    else
    begin
      if (instValid)
        skipPending <= execute && next_skip;
      retired   <= execute;
      idleCycle <= instValid && skipPending;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ABD_APB_ZERO;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !apbHit(paddr);
      prdata  <= `ABD_APB_ZERO;
      if (psel && penable && !pready && !pwrite)
      begin
        unique case (paddr)
          `ABD_REG_CTRL:
            prdata[`ABD_CTRL_PSA_BIT] <= prescalerAssigned;
          `ABD_REG_ACC:
            prdata[`ABD_DATA_W-1:0] <= accumulator;
          `ABD_REG_STATUS:
          begin
            prdata[`ABD_STAT_C_BIT]    <= flags.carry;
            prdata[`ABD_STAT_HC_BIT]   <= flags.half_carry_flag;
            prdata[`ABD_STAT_Z_BIT]    <= flags.zero;
            prdata[`ABD_STAT_SKIP_BIT] <= skipPending;
          end
          default:
            prdata <= `ABD_APB_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      prescalerAssigned <= `ABD_CTRL_RESET;
    else if (psel && penable && pready && pwrite && paddr == `ABD_REG_CTRL)
      prescalerAssigned <= pwdata[`ABD_CTRL_PSA_BIT];
  end

endmodule

`default_nettype wire

/* logic/abd_defines.svh */
`ifndef ABD_DEFINES_SVH
`define ABD_DEFINES_SVH

// APB register byte offsets
`define ABD_REG_CTRL        8'h00
`define ABD_REG_ACC         8'h04
`define ABD_REG_STATUS      8'h08

// Control register fields
`define ABD_CTRL_PSA_BIT    0
`define ABD_CTRL_RESET      1'h0

// Status register fields
`define ABD_STAT_C_BIT      0
`define ABD_STAT_HC_BIT     1
`define ABD_STAT_Z_BIT      2
`define ABD_STAT_SKIP_BIT   3

// Special file register addresses
`define ABD_ADDR_TIMER_ZERO 7'h01
`define ABD_ADDR_PORT       7'h05

// Widths and reset values
`define ABD_DATA_W          8
`define ABD_ADDR_W          7
`define ABD_ACC_RESET       8'h00
`define ABD_PORT_RESET      8'h00
`define ABD_NIBBLE_W        4
`define ABD_ZERO_BYTE       8'h00
`define ABD_APB_ZERO        32'h0000_0000
`define ABD_DEST_ACC        1'h0

`endif

/* logic/abd_pkg.sv */
`default_nettype none
package abd_pkg;

  typedef enum logic [2:0] {
    add_immediate_to_accumulator,
    add_accumulator_and_register,
    and_immediate_with_accumulator,
    and_accumulator_with_register,
    register_bit_clear,
    register_bit_set,
    test_bit_skip_when_zero,
    test_bit_skip_when_one
  } abd_op_t;

  typedef struct packed {
    abd_op_t    op;
    logic [7:0] literal;
    logic [6:0] fileAddr;
    logic       dest;
    logic [2:0] bitPos;
  } abd_instr_t;

  typedef struct packed {
    logic zero;
    logic half_carry_flag;
    logic carry;
  } abd_flags_t;

endpackage
`default_nettype wire

/* verif/abd_datapath_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module abd_datapath_chk (
  // Clock and reset
  input wire logic                clk,
  input wire logic                srst,
  // Instruction side
  input wire logic                instValid,
  input wire abd_pkg::abd_instr_t instr,
  input wire logic [7:0]          accumulator,
  input wire abd_pkg::abd_flags_t flags,
  input wire logic                retired,
  input wire logic                idleCycle
);
  abd_pkg::abd_instr_t last;
  logic                addI;
  logic                andI;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // Instruction taken one edge ago
  always_ff @(posedge clk)
  begin
    last <= instr;
  end
  assign addI = retired && last.op == abd_pkg::add_immediate_to_accumulator;
  assign andI = retired && last.op == abd_pkg::and_immediate_with_accumulator;
  chk_add_sum:
    assert property (addI |-> {flags.carry, accumulator}
      == {1'b0, $past(accumulator)} + {1'b0, last.literal}) else $error("add sum wrong");
  chk_half_carry:
    assert property (addI |-> flags.half_carry_flag
      == ({1'b0, $past(accumulator[3:0])} + {1'b0, last.literal[3:0]} > 5'h0f))
      else $error("half carry wrong");
  chk_and_keep:
    assert property (andI |-> accumulator == ($past(accumulator) & last.literal)
      && flags[1:0] == $past(flags[1:0])) else $error("and result or flags wrong");
  chk_zero_flag:
    assert property (addI || andI |-> flags.zero == (accumulator == 8'h00))
      else $error("zero flag wrong");
  chk_dest_file:
    assert property (retired && last.dest && last.op inside
      {abd_pkg::add_accumulator_and_register, abd_pkg::and_accumulator_with_register}
      |-> $stable(accumulator)) else $error("file destination touched accumulator");
  chk_bit_quiet:
    assert property (retired && last.op >= abd_pkg::register_bit_clear
      |-> $stable(flags) && $stable(accumulator)) else $error("bit op changed state");
  chk_skip_idle:
    assert property (idleCycle |-> !retired && $stable(accumulator) && $stable(flags))
      else $error("discarded instruction changed state");
  chk_one_cycle:
    assert property (instValid |=> retired ^ idleCycle) else $error("no completion pulse");
endmodule
bind abd_datapath abd_datapath_chk u_chk (.clk, .srst, .instValid, .instr, .accumulator,
  .flags, .retired, .idleCycle);
`default_nettype wire

/* verif/abd_decode_model.sv */
`timescale 1ns/100ps
`default_nettype none
module abd_decode_model (
  // Issue side and pins
  input  wire logic                clk,
  output var  logic                instValid,
  output var  abd_pkg::abd_instr_t instr,
  output var  logic [7:0]          portPins
);
  initial
  begin
    instValid <= 1'b0;
    instr <= '0;
  end
  task automatic issue(input abd_pkg::abd_op_t op, input logic [7:0] k,
                       input logic [6:0] f, input logic d, input logic [2:0] b);
    instValid <= 1'b1;
    instr <= {op, k, f, d, b};
    @(posedge clk);
  endtask
  // Released bus shows the inverse word
  task automatic idle();
    instValid <= 1'b0;
    instr <= ~instr;
    @(posedge clk);
  endtask
  task automatic setPins(input logic [7:0] v);
    portPins <= v;
  endtask
endmodule
`default_nettype wire

/* verif/tb_add_and_bit_ops_datapath.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_add_and_bit_ops_datapath;
  logic                clk = 1'b0;
  logic                srst = 1'b1;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic [31:0]         rd;
  logic                pready, pslverr, instValid, idleCycle, retired, prescalerClear, er;
  logic [7:0]          portPins, portLatch, accumulator;
  abd_pkg::abd_instr_t instr;
  abd_pkg::abd_flags_t flags;
  int                  fails = 0;
  int                  numChecks = 0;
  int                  cycles = 0;
  always #2 clk = ~clk;
  abd_datapath uut (.clk, .srst, .instValid, .instr, .portPins, .portLatch, .prescalerClear,
    .accumulator, .flags, .retired, .idleCycle, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  abd_decode_model src (.clk, .instValid, .instr, .portPins);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Execute one instruction, then compare {acc, flags, latch}
  task automatic run(input abd_pkg::abd_op_t op, input logic [7:0] k, input logic [6:0] f,
                     input logic d, input logic [2:0] b, input logic [18:0] e);
    src.issue(op, k, f, d, b);
    src.idle();
    check({accumulator, flags, portLatch}, e);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      fails++;
      closeOut();
    end
  end
  initial
  begin
    src.setPins(8'hc3);
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    check({rd[30:0], er}, 32'h1);
    run(abd_pkg::add_immediate_to_accumulator, 8'hff, 7'h00, 1'b0, 3'h0, 19'h7f800);
    run(abd_pkg::add_immediate_to_accumulator, 8'h3d, 7'h00, 1'b0, 3'h0, 19'h1e300);
    run(abd_pkg::and_immediate_with_accumulator, 8'hc3, 7'h00, 1'b0, 3'h0, 19'h00700);
    run(abd_pkg::add_immediate_to_accumulator, 8'h55, 7'h00, 1'b0, 3'h0, 19'h2a800);
    run(abd_pkg::add_accumulator_and_register, 8'h00, 7'h05, 1'b1, 3'h0, 19'h2a918);
    run(abd_pkg::add_accumulator_and_register, 8'h00, 7'h05, 1'b0, 3'h0, 19'h0c118);
    run(abd_pkg::and_accumulator_with_register, 8'h00, 7'h05, 1'b0, 3'h0, 19'h00518);
    run(abd_pkg::and_accumulator_with_register, 8'h00, 7'h05, 1'b1, 3'h0, 19'h00500);
    run(abd_pkg::register_bit_set, 8'h00, 7'h05, 1'b0, 3'h2, 19'h005c7);
    run(abd_pkg::register_bit_clear, 8'h00, 7'h05, 1'b0, 3'h0, 19'h005c2);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h5);
    for (int i = 0; i < 4; i++)
    begin
      src.issue(i < 2 ? abd_pkg::test_bit_skip_when_zero : abd_pkg::test_bit_skip_when_one,
                8'h00, 7'h05, 1'b0, i == 2 ? 3'h7 : (i == 1 ? 3'h0 : 3'h2));
      src.issue(abd_pkg::add_immediate_to_accumulator, 8'h01, 7'h00, 1'b0, 3'h0);
      // Pulses stand only in the cycle after the edge
      fork
        src.idle();
        begin
          #1;
          check(idleCycle, i % 2 == 0);
          check(accumulator, (i + 1) / 2);
        end
      join
    end
    for (int j = 0; j < 2; j++)
    begin
      src.issue(j ? abd_pkg::test_bit_skip_when_zero : abd_pkg::register_bit_set,
                8'h00, 7'h01, 1'b0, 3'h0);
      fork
        src.idle();
        begin
          #1;
          check(prescalerClear, j == 0);
        end
      join
    end
    closeOut();
  end
endmodule
`default_nettype wire
